// ---- fsf_pkg.sv ----
`default_nettype none
package fsf_pkg;

    // *****************************************************************
    // Bus geometry
    // *****************************************************************
    localparam int unsigned FSF_ADDR_W = 8;
    localparam int unsigned FSF_DATA_W = 32;
    localparam int unsigned FSF_STRB_W = FSF_DATA_W / 8;

    // *****************************************************************
    // Register byte offsets
    // *****************************************************************
    localparam logic [FSF_ADDR_W-1:0] FSF_OFS_STATUS2 = 8'h00;
    localparam logic [FSF_ADDR_W-1:0] FSF_OFS_CRC_START = 8'h04;
    localparam logic [FSF_ADDR_W-1:0] FSF_OFS_CRC_END = 8'h08;
    localparam logic [FSF_ADDR_W-1:0] FSF_OFS_EVAL_SECTOR = 8'h0c;
    localparam logic [FSF_ADDR_W-1:0] FSF_OFS_COMMAND = 8'h10;
    localparam int unsigned FSF_WORD_LSB = 2;

    // *****************************************************************
    // Field positions and values
    // *****************************************************************
    localparam int unsigned FSF_BIT_PROG_SUSP = 0;
    localparam int unsigned FSF_BIT_ERASE_SUSP = 1;
    localparam int unsigned FSF_BIT_ERASE_RESULT = 2;
    localparam int unsigned FSF_BIT_CRC_ABORT = 3;
    localparam int unsigned FSF_BIT_CMD_CRC = 0;
    localparam int unsigned FSF_BIT_CMD_EVAL = 1;
    localparam logic [7:0] FSF_STATUS2_RESET = 8'h00;
    localparam logic [32:0] FSF_CRC_MIN_SPAN = 33'h000000003;
    localparam logic [1:0] FSF_RESP_OKAY = 2'b00;
    localparam logic [1:0] FSF_RESP_SLVERR = 2'b10;

    // *****************************************************************
    // Types
    // *****************************************************************
    typedef struct packed {
        logic crc_check_abort_flag;
        logic sector_erase_result_flag;
        logic erase_suspended_flag;
        logic program_suspended_flag;
    } fsf_flags_t;

    typedef enum logic [0:0] {FSF_CRC_IDLE, FSF_CRC_RUN} fsf_crc_state_t;
    typedef enum logic [0:0] {FSF_EV_IDLE, FSF_EV_WAIT} fsf_eval_state_t;

endpackage
`default_nettype wire

// ---- fsf_status_two.sv ----
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
// Contract
// - End below start plus three sets abort
// - Valid address span clears abort flag
// - CRC abort flag sits at bit 3
// - Erase result bit 2, 1 means success
// - Evaluate command loads result for sector
// - Erase suspend flag at bit 1
// - Program suspend flag at bit 0
// - Flags read-only, zero after reset
module fsf_status_two
    import fsf_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [FSF_ADDR_W-1:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [FSF_DATA_W-1:0] S_AXI_WDATA_IN,
    input wire logic [FSF_STRB_W-1:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [FSF_ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [FSF_DATA_W-1:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    input wire logic ERASE_SUSPENDED_IN,
    input wire logic PROGRAM_SUSPENDED_IN,
    output logic CRC_START_OUT,
    output logic [FSF_DATA_W-1:0] CRC_START_ADDR_OUT,
    output logic [FSF_DATA_W-1:0] CRC_END_ADDR_OUT,
    input wire logic CRC_DONE_IN,
    output logic EVAL_REQ_OUT,
    output logic [FSF_DATA_W-1:0] EVAL_SECTOR_OUT,
    input wire logic EVAL_DONE_IN,
    input wire logic EVAL_PASS_IN,
    output logic [7:0] STATUS2_OUT
);

    // *****************************************************************
    // Declarations
    // *****************************************************************
    logic awready_ff;
    logic wready_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [FSF_ADDR_W-1:0] awaddr_ff;
    logic [FSF_DATA_W-1:0] wdata_ff;
    logic [FSF_STRB_W-1:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [FSF_DATA_W-1:0] rdata_ff;
    logic [FSF_DATA_W-1:0] crc_start_ff;
    logic [FSF_DATA_W-1:0] crc_end_ff;
    logic [FSF_DATA_W-1:0] eval_sector_ff;
    logic crc_start_pulse_ff;
    logic eval_req_ff;
    fsf_flags_t flags_ff;
    fsf_crc_state_t crc_state_ff;
    fsf_eval_state_t eval_state_ff;
    logic wr_commit;
    logic wr_mapped;
    logic cmd_crc;
    logic cmd_eval;
    logic span_ok;
    logic [7:0] status2_view;
    logic [FSF_DATA_W-1:0] nxt_rdata;
    logic nxt_rmapped;

    // Byte-lane merge for the address registers
    function automatic logic [FSF_DATA_W-1:0] merge_bytes(
        input logic [FSF_DATA_W-1:0] old_val,
        input logic [FSF_DATA_W-1:0] new_val,
        input logic [FSF_STRB_W-1:0] strb
    );
        logic [FSF_DATA_W-1:0] res;
        res = old_val;
        for (int i = 0; i < FSF_STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // *****************************************************************
    // AXI4-Lite write channels
    // *****************************************************************
    // Commit happens once both halves are held; readies stay low until
    // the response is taken, so only one write is ever in flight
    assign wr_commit = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_mapped = (awaddr_ff == FSF_OFS_STATUS2) || (awaddr_ff == FSF_OFS_CRC_START) ||
                       (awaddr_ff == FSF_OFS_CRC_END) || (awaddr_ff == FSF_OFS_EVAL_SECTOR) ||
                       (awaddr_ff == FSF_OFS_COMMAND);

    // Address channel capture
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            awaddr_ff <= '0;
        end else if (S_AXI_AWVALID_IN && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            awaddr_ff <= {S_AXI_AWADDR_IN[FSF_ADDR_W-1:FSF_WORD_LSB], 2'b00};
        end else if (wr_commit) begin
            aw_held_ff <= 1'b0;
        end else if (bvalid_ff && S_AXI_BREADY_IN) begin
            awready_ff <= 1'b1;
        end
    end

    // Data channel capture
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else if (S_AXI_WVALID_IN && wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA_IN;
            wstrb_ff <= S_AXI_WSTRB_IN;
        end else if (wr_commit) begin
            w_held_ff <= 1'b0;
        end else if (bvalid_ff && S_AXI_BREADY_IN) begin
            wready_ff <= 1'b1;
        end
    end

    // Write response; the status word accepts writes silently
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= FSF_RESP_OKAY;
        end else if (wr_commit) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? FSF_RESP_OKAY : FSF_RESP_SLVERR;
        end else if (bvalid_ff && S_AXI_BREADY_IN) begin
            bvalid_ff <= 1'b0;
        end
    end

    // *****************************************************************
    // Software registers
    // *****************************************************************
    // Address words; held while an operation runs so the engine sees
    // a stable range
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            crc_start_ff <= '0;
            crc_end_ff <= '0;
            eval_sector_ff <= '0;
        end else if (wr_commit) begin
            if (awaddr_ff == FSF_OFS_CRC_START && crc_state_ff == FSF_CRC_IDLE) begin
                crc_start_ff <= merge_bytes(crc_start_ff, wdata_ff, wstrb_ff);
            end
            if (awaddr_ff == FSF_OFS_CRC_END && crc_state_ff == FSF_CRC_IDLE) begin
                crc_end_ff <= merge_bytes(crc_end_ff, wdata_ff, wstrb_ff);
            end
            if (awaddr_ff == FSF_OFS_EVAL_SECTOR && eval_state_ff == FSF_EV_IDLE) begin
                eval_sector_ff <= merge_bytes(eval_sector_ff, wdata_ff, wstrb_ff);
            end
        end
    end

    // Command strobes; a command to a busy engine is dropped
    assign cmd_crc = wr_commit && (awaddr_ff == FSF_OFS_COMMAND) && wstrb_ff[0] &&
                     wdata_ff[FSF_BIT_CMD_CRC] && (crc_state_ff == FSF_CRC_IDLE);
    assign cmd_eval = wr_commit && (awaddr_ff == FSF_OFS_COMMAND) && wstrb_ff[0] &&
                      wdata_ff[FSF_BIT_CMD_EVAL] && (eval_state_ff == FSF_EV_IDLE);

    // 33-bit sum so a start near the top of the space cannot wrap
    assign span_ok = ({1'b0, crc_end_ff} >= ({1'b0, crc_start_ff} + FSF_CRC_MIN_SPAN));

    // *****************************************************************
    // Integrity CRC sequencing
    // *****************************************************************
    // A bad span never reaches the engine: the block stays idle
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            crc_state_ff <= FSF_CRC_IDLE;
            crc_start_pulse_ff <= 1'b0;
        end else begin
            crc_start_pulse_ff <= 1'b0;
            case (crc_state_ff)
                FSF_CRC_IDLE: begin
                    if (cmd_crc && span_ok) begin
                        crc_state_ff <= FSF_CRC_RUN;
                        crc_start_pulse_ff <= 1'b1;
                    end
                end
                FSF_CRC_RUN: begin
                    if (CRC_DONE_IN) begin
                        crc_state_ff <= FSF_CRC_IDLE;
                    end
                end
                default: begin
                    crc_state_ff <= FSF_CRC_IDLE;
                end
            endcase
        end
    end

    // Abort flag: set on a short span, cleared on a good one
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            flags_ff.crc_check_abort_flag <= 1'b0;
        end else if (cmd_crc && !span_ok) begin
            flags_ff.crc_check_abort_flag <= 1'b1;
        end else if (cmd_crc && span_ok) begin
            flags_ff.crc_check_abort_flag <= 1'b0;
        end
    end

    // *****************************************************************
    // Evaluate erase status
    // *****************************************************************
    // Flag only changes when the lookup for the named sector returns
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            eval_state_ff <= FSF_EV_IDLE;
            eval_req_ff <= 1'b0;
            flags_ff.sector_erase_result_flag <= 1'b0;
        end else begin
            eval_req_ff <= 1'b0;
            case (eval_state_ff)
                FSF_EV_IDLE: begin
                    if (cmd_eval) begin
                        eval_state_ff <= FSF_EV_WAIT;
                        eval_req_ff <= 1'b1;
                    end
                end
                FSF_EV_WAIT: begin
                    if (EVAL_DONE_IN) begin
                        eval_state_ff <= FSF_EV_IDLE;
                        flags_ff.sector_erase_result_flag <= EVAL_PASS_IN;
                    end
                end
                default: begin
                    eval_state_ff <= FSF_EV_IDLE;
                end
            endcase
        end
    end

    // *****************************************************************
    // Suspend flags
    // *****************************************************************
    // Follow the engine levels one cycle late
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            flags_ff.erase_suspended_flag <= 1'b0;
            flags_ff.program_suspended_flag <= 1'b0;
        end else begin
            flags_ff.erase_suspended_flag <= ERASE_SUSPENDED_IN;
            flags_ff.program_suspended_flag <= PROGRAM_SUSPENDED_IN;
        end
    end

    // Status word packing; upper bits stay zero
    always_comb begin
        status2_view = FSF_STATUS2_RESET;
        status2_view[FSF_BIT_CRC_ABORT] = flags_ff.crc_check_abort_flag;
        status2_view[FSF_BIT_ERASE_RESULT] = flags_ff.sector_erase_result_flag;
        status2_view[FSF_BIT_ERASE_SUSP] = flags_ff.erase_suspended_flag;
        status2_view[FSF_BIT_PROG_SUSP] = flags_ff.program_suspended_flag;
    end

    // *****************************************************************
    // AXI4-Lite read channel
    // *****************************************************************
    // Read mux; no write path reaches the flags, so they are read-only
    always_comb begin
        nxt_rdata = '0;
        nxt_rmapped = 1'b1;
        case ({S_AXI_ARADDR_IN[FSF_ADDR_W-1:FSF_WORD_LSB], 2'b00})
            FSF_OFS_STATUS2: nxt_rdata[7:0] = status2_view;
            FSF_OFS_CRC_START: nxt_rdata = crc_start_ff;
            FSF_OFS_CRC_END: nxt_rdata = crc_end_ff;
            FSF_OFS_EVAL_SECTOR: nxt_rdata = eval_sector_ff;
            FSF_OFS_COMMAND: begin
                nxt_rdata[FSF_BIT_CMD_CRC] = (crc_state_ff == FSF_CRC_RUN);
                nxt_rdata[FSF_BIT_CMD_EVAL] = (eval_state_ff == FSF_EV_WAIT);
            end
            default: nxt_rmapped = 1'b0;
        endcase
    end

    // One read in flight; data captured at the address handshake
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= FSF_RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rmapped ? FSF_RESP_OKAY : FSF_RESP_SLVERR;
        end else if (rvalid_ff && S_AXI_RREADY_IN) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
        end
    end

    // *****************************************************************
    // Outputs
    // *****************************************************************
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            STATUS2_OUT <= FSF_STATUS2_RESET;
        end else begin
            STATUS2_OUT <= status2_view;
        end
    end

    assign S_AXI_AWREADY_OUT = awready_ff;
    assign S_AXI_WREADY_OUT = wready_ff;
    assign S_AXI_BVALID_OUT = bvalid_ff;
    assign S_AXI_BRESP_OUT = bresp_ff;
    assign S_AXI_ARREADY_OUT = arready_ff;
    assign S_AXI_RVALID_OUT = rvalid_ff;
    assign S_AXI_RDATA_OUT = rdata_ff;
    assign S_AXI_RRESP_OUT = rresp_ff;
    assign CRC_START_OUT = crc_start_pulse_ff;
    assign CRC_START_ADDR_OUT = crc_start_ff;
    assign CRC_END_ADDR_OUT = crc_end_ff;
    assign EVAL_REQ_OUT = eval_req_ff;
    assign EVAL_SECTOR_OUT = eval_sector_ff;

endmodule
`default_nettype wire

// ---- fsf_status_two_ports.sv ----
`default_nettype none
`default_nettype wire

// ---- fsf_status_two_props.sv ----
`default_nettype none
module fsf_status_two_props
    import fsf_pkg::*;
(
    input wire logic SYS_CLK_IN,
    input wire logic RST_N_IN,
    input wire logic S_AXI_BVALID_OUT,
    input wire logic [FSF_ADDR_W-1:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    input wire logic S_AXI_ARREADY_OUT,
    input wire logic S_AXI_RVALID_OUT,
    input wire logic [FSF_DATA_W-1:0] S_AXI_RDATA_OUT,
    input wire logic ERASE_SUSPENDED_IN,
    input wire logic PROGRAM_SUSPENDED_IN,
    input wire logic CRC_START_OUT,
    input wire logic [FSF_DATA_W-1:0] CRC_START_ADDR_OUT,
    input wire logic [FSF_DATA_W-1:0] CRC_END_ADDR_OUT,
    input wire logic EVAL_REQ_OUT,
    input wire logic EVAL_DONE_IN,
    input wire logic EVAL_PASS_IN,
    input wire logic [7:0] STATUS2_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Helpers
    // ********
    logic eval_pend_ff;
    logic [1:0] age_ff;
    logic eval_hit;
    logic rd_stat_ff;
    assign eval_hit = eval_pend_ff && EVAL_DONE_IN;
    // Marks a read of the status word; the address registers carry full words
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rd_stat_ff <= 1'b0;
        end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
            rd_stat_ff <= (S_AXI_ARADDR_IN[7:2] == FSF_OFS_STATUS2[7:2]);
        end
    end
    // Lookup in flight, so stray done pulses are not mistaken for results
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            eval_pend_ff <= 1'b0;
        end else if (EVAL_REQ_OUT) begin
            eval_pend_ff <= 1'b1;
        end else if (EVAL_DONE_IN) begin
            eval_pend_ff <= 1'b0;
        end
    end
    // Edges since reset; $past must not reach back into reset
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            age_ff <= 2'h0;
        end else if (age_ff != 2'h3) begin
            age_ff <= age_ff + 2'h1;
        end
    end
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // ********
    // Assertions
    // ********
    a_start_span: assert property (CRC_START_OUT |->
        ({1'b0, CRC_END_ADDR_OUT} >= {1'b0, CRC_START_ADDR_OUT} + FSF_CRC_MIN_SPAN))
        else $error("crc launched with short span");
    a_start_clears: assert property (CRC_START_OUT |=> !STATUS2_OUT[3])
        else $error("abort flag kept after good launch");
    a_abort_cause: assert property ($rose(STATUS2_OUT[3]) |->
        $past(S_AXI_BVALID_OUT) && !$past(CRC_START_OUT))
        else $error("abort flag rose without command");
    a_upper_zero: assert property (STATUS2_OUT[7:4] == 4'h0)
        else $error("status upper bits set");
    a_erase_track: assert property (age_ff == 2'h3 |->
        STATUS2_OUT[1] == $past(ERASE_SUSPENDED_IN, 2))
        else $error("erase suspend bit wrong");
    a_prog_track: assert property (age_ff == 2'h3 |->
        STATUS2_OUT[0] == $past(PROGRAM_SUSPENDED_IN, 2))
        else $error("program suspend bit wrong");
    a_eval_load: assert property (eval_hit |-> ##2 STATUS2_OUT[2] == $past(EVAL_PASS_IN, 2))
        else $error("erase result not loaded");
    a_eval_hold: assert property ($changed(STATUS2_OUT[2]) |-> $past(eval_hit, 2))
        else $error("erase result moved by itself");
    a_rdata_upper: assert property ($rose(S_AXI_RVALID_OUT) && rd_stat_ff |->
        S_AXI_RDATA_OUT == {24'h0, STATUS2_OUT})
        else $error("status read data wrong");
    a_reset_zero: assert property ($rose(RST_N_IN) |-> STATUS2_OUT == FSF_STATUS2_RESET)
        else $error("status not cleared by reset");
    c_launch: cover property (CRC_START_OUT);
    c_abort: cover property ($rose(STATUS2_OUT[3]));
    c_pass: cover property (eval_hit && EVAL_PASS_IN);
endmodule
bind fsf_status_two fsf_status_two_props fsf_status_two_props_i (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT),
    .S_AXI_ARADDR_IN(S_AXI_ARADDR_IN), .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN),
    .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
    .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT),
    .ERASE_SUSPENDED_IN(ERASE_SUSPENDED_IN), .PROGRAM_SUSPENDED_IN(PROGRAM_SUSPENDED_IN),
    .CRC_START_OUT(CRC_START_OUT), .CRC_START_ADDR_OUT(CRC_START_ADDR_OUT),
    .CRC_END_ADDR_OUT(CRC_END_ADDR_OUT), .EVAL_REQ_OUT(EVAL_REQ_OUT),
    .EVAL_DONE_IN(EVAL_DONE_IN), .EVAL_PASS_IN(EVAL_PASS_IN), .STATUS2_OUT(STATUS2_OUT));
`default_nettype wire

// ---- fsf_engine_model.sv ----
`default_nettype none
module fsf_engine_model
    import fsf_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic slow_in,
    input wire logic crc_start_in,
    input wire logic eval_req_in,
    input wire logic [FSF_DATA_W-1:0] eval_sector_in,
    output logic crc_done_out,
    output logic eval_done_out,
    output logic eval_pass_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] crc_cnt_ff;
    logic [3:0] ev_cnt_ff;
    logic junk_ff;
    // Both engines busy for a short or long spell, then one done pulse
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            crc_cnt_ff <= 4'h0;
            ev_cnt_ff <= 4'h0;
            junk_ff <= 1'b0;
        end else begin
            junk_ff <= ~junk_ff;
            if (crc_start_in) begin
                crc_cnt_ff <= slow_in ? 4'h9 : 4'h1;
            end else if (crc_cnt_ff != 4'h0) begin
                crc_cnt_ff <= crc_cnt_ff - 4'h1;
            end
            if (eval_req_in) begin
                ev_cnt_ff <= slow_in ? 4'h9 : 4'h1;
            end else if (ev_cnt_ff != 4'h0) begin
                ev_cnt_ff <= ev_cnt_ff - 4'h1;
            end
        end
    end
    // Result line toggles outside its valid cycle so stale values never pass
    assign crc_done_out = (crc_cnt_ff == 4'h1);
    assign eval_done_out = (ev_cnt_ff == 4'h1);
    assign eval_pass_out = eval_done_out ? ~eval_sector_in[0] : junk_ff;
endmodule
`default_nettype wire

// ---- fsf_status_two_tb.sv ----
`default_nettype none
module fsf_status_two_tb
    import fsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] s;
        logic [31:0] e;
        logic es;
        logic ps;
        logic [7:0] x;
    } fsf_row_t;
    logic clk, rst_n, awv, wv, bready, arv, rready, esus, psus, slow;
    logic awrdy, wrdy, bvalid, arrdy, rvalid, crc_start, crc_done, ev_req, ev_done, ev_pass;
    logic [7:0] awaddr, araddr, status2;
    logic [31:0] wdata, rdata, s_addr, e_addr, sector, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int n_mismatch, checks_done;
    fsf_row_t rows[5] = '{'{32'h100, 32'h103, 1'b0, 1'b0, 8'h00},
        '{32'h100, 32'h102, 1'b1, 1'b0, 8'h0a}, '{32'h200, 32'h100, 1'b0, 1'b1, 8'h09},
        '{32'hffff_fffe, 32'h1, 1'b1, 1'b1, 8'h0b}, '{32'h0, 32'h3, 1'b0, 1'b0, 8'h00}};
    fsf_status_two fsf_status_two_i (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awrdy),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wv),
        .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv),
        .S_AXI_ARREADY_OUT(arrdy), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .ERASE_SUSPENDED_IN(esus),
        .PROGRAM_SUSPENDED_IN(psus), .CRC_START_OUT(crc_start), .CRC_START_ADDR_OUT(s_addr),
        .CRC_END_ADDR_OUT(e_addr), .CRC_DONE_IN(crc_done), .EVAL_REQ_OUT(ev_req),
        .EVAL_SECTOR_OUT(sector), .EVAL_DONE_IN(ev_done), .EVAL_PASS_IN(ev_pass),
        .STATUS2_OUT(status2));
    fsf_engine_model fsf_engine_model_i (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow),
        .crc_start_in(crc_start), .eval_req_in(ev_req), .eval_sector_in(sector),
        .crc_done_out(crc_done), .eval_done_out(ev_done), .eval_pass_out(ev_pass));
    // ********
    // Reporting
    // ********
    task close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task tmo;
        n_mismatch++;
        $display("[ERR] %0t handshake timeout", $time);
        close_out;
    endtask
    // ********
    // Bus master; ready sampled at the falling edge, so the handshake edge is known
    // ********
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        logic ta, tw, ra, rw;
        @(posedge clk);
        awaddr <= a; wdata <= v; wstrb <= 4'hf; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        ta = 1'b0; tw = 1'b0; n = 0;
        while (!(ta && tw)) begin
            @(negedge clk); ra = awrdy; rw = wrdy; n++;
            if (n > 50) tmo;
            @(posedge clk);
            if (ra && !ta) begin ta = 1'b1; awv <= 1'b0; end
            if (rw && !tw) begin tw = 1'b1; wv <= 1'b0; end
        end
        n = 0;
        do begin @(negedge clk); n++; if (n > 50) tmo; end while (bvalid !== 1'b1);
        rs = bresp;
        @(posedge clk); bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        @(posedge clk); araddr <= a; arv <= 1'b1; rready <= 1'b1; n = 0;
        do begin @(negedge clk); n++; if (n > 50) tmo; end while (arrdy !== 1'b1);
        @(posedge clk); arv <= 1'b0; n = 0;
        while (rvalid !== 1'b1) begin @(negedge clk); n++; if (n > 50) tmo; end
        v = rdata; rs = rresp;
        @(posedge clk); rready <= 1'b0;
    endtask
    task idle;
        int n;
        n = 0; d = 32'h3;
        while (d[1:0] !== 2'h0) begin rd(FSF_OFS_COMMAND, d, r); n++; if (n > 30) tmo; end
    endtask
    initial begin clk = 1'b0; forever #2 clk = ~clk; end
    initial begin repeat (20000) @(posedge clk); tmo; end
    // ********
    // Main sequence
    // ********
    initial begin
        {rst_n, awv, wv, bready, arv, rready, esus, psus, slow} = '0;
        awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; n_mismatch = 0; checks_done = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(FSF_OFS_STATUS2, d, r); chk(d, 32'h0);
        foreach (rows[i]) begin
            esus <= rows[i].es; psus <= rows[i].ps;
            wr(FSF_OFS_CRC_START, rows[i].s, r);
            wr(FSF_OFS_CRC_END, rows[i].e, r);
            wr(FSF_OFS_COMMAND, 32'h1, r); idle;
            rd(FSF_OFS_STATUS2, d, r); chk(d, {24'h0, rows[i].x});
        end
        wr(FSF_OFS_STATUS2, 32'hff, r); chk(r, FSF_RESP_OKAY);
        rd(FSF_OFS_STATUS2, d, r); chk(d, 32'h0);
        rd(8'h40, d, r); chk(d, 32'h0); chk(r, FSF_RESP_SLVERR);
        slow <= 1'b1;
        for (int k = 4; k < 7; k++) begin
            wr(FSF_OFS_EVAL_SECTOR, k, r);
            wr(FSF_OFS_COMMAND, 32'h2, r); idle;
            rd(FSF_OFS_STATUS2, d, r); chk(d, (k == 5) ? 32'h0 : 32'h4);
        end
        @(posedge clk); rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(FSF_OFS_STATUS2, d, r); chk(d, 32'h0);
        close_out;
    end
endmodule
`default_nettype wire
